// file: core/brl_pkg.sv
// package: opcode encodings, field positions and status layout
package brl_pkg;

    // ----------------------------------------------------------------
    // instruction word fields
    // ----------------------------------------------------------------
    localparam int INSN_W = 12;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 5;
    localparam int OP4_HI = 11;
    localparam int OP4_LO = 8;
    localparam int OP6_HI = 11;
    localparam int OP6_LO = 6;
    localparam int DEST_POS = 5;
    localparam int BIT_HI = 7;
    localparam int BIT_LO = 5;
    localparam int FILE_HI = 4;
    localparam int FILE_LO = 0;
    localparam int LIT_HI = 7;
    localparam int LIT_LO = 0;

    // ----------------------------------------------------------------
    // byte-wide file opcodes, bits 11..6
    // ----------------------------------------------------------------
    localparam logic [5:0] OP_INVERT = 6'h09;
    localparam logic [5:0] OP_ROT_RIGHT = 6'h0C;
    localparam logic [5:0] OP_ROT_LEFT = 6'h0D;
    localparam logic [5:0] OP_NIB_EXCH = 6'h0E;

    // ----------------------------------------------------------------
    // bit-level and literal opcodes, bits 11..8
    // ----------------------------------------------------------------
    localparam logic [3:0] OP_CLR_BIT = 4'h4;
    localparam logic [3:0] OP_SET_BIT = 4'h5;
    localparam logic [3:0] OP_SKIP_LOW = 4'h6;
    localparam logic [3:0] OP_SKIP_HIGH = 4'h7;
    localparam logic [3:0] OP_LOAD_IMM = 4'hC;
    localparam logic [3:0] OP_MASK_IMM = 4'hE;

    // ----------------------------------------------------------------
    // status bit positions and reset values
    // ----------------------------------------------------------------
    localparam int ST_CARRY = 0;
    localparam int ST_DCARRY = 1;
    localparam int ST_ZERO = 2;
    localparam logic [2:0] STATUS_RST = 3'h0;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [4:0] INDIRECT_ADDR = 5'h00;
    localparam logic [4:0] FSR_ADDR = 5'h04;
    localparam logic [11:0] NOP_WORD = 12'h000;

    typedef enum logic [1:0] {
        BRL_IDLE = 2'b01,
        BRL_EXEC = 2'b10
    } brl_state_type;

endpackage : brl_pkg

// file: core/brl_dec_if.sv
// interface: decoded instruction fields between decoder and datapath
`timescale 1ns/1ps
interface brl_dec_if;
    logic [4:0] file_addr;
    logic [2:0] bit_num;
    logic [7:0] literal;
    logic dest_file;
    logic is_invert;
    logic is_rot_left;
    logic is_rot_right;
    logic is_nib_exch;
    logic is_clr_bit;
    logic is_set_bit;
    logic is_skip_low;
    logic is_skip_high;
    logic is_load_imm;
    logic is_mask_imm;
    modport dec (output file_addr, bit_num, literal, dest_file, is_invert,
        is_rot_left, is_rot_right, is_nib_exch, is_clr_bit, is_set_bit,
        is_skip_low, is_skip_high, is_load_imm, is_mask_imm);
    modport exe (input file_addr, bit_num, literal, dest_file, is_invert,
        is_rot_left, is_rot_right, is_nib_exch, is_clr_bit, is_set_bit,
        is_skip_low, is_skip_high, is_load_imm, is_mask_imm);
endinterface : brl_dec_if

// file: core/brl_decode.sv
// module: field decoder for file, bit-level and literal instructions
`timescale 1ns/1ps
module brl_decode import brl_pkg::*; (
    input wire logic [11:0] insn, // instruction word, already skip-gated
    brl_dec_if.dec d // decoded fields
);
    wire [5:0] op6 = insn[OP6_HI:OP6_LO];
    wire [3:0] op4 = insn[OP4_HI:OP4_LO];

    assign d.file_addr = insn[FILE_HI:FILE_LO];
    assign d.bit_num = insn[BIT_HI:BIT_LO];
    assign d.literal = insn[LIT_HI:LIT_LO];
    assign d.dest_file = insn[DEST_POS];
    assign d.is_invert = (op6 == OP_INVERT);
    assign d.is_rot_left = (op6 == OP_ROT_LEFT);
    assign d.is_rot_right = (op6 == OP_ROT_RIGHT);
    assign d.is_nib_exch = (op6 == OP_NIB_EXCH);
    assign d.is_clr_bit = (op4 == OP_CLR_BIT);
    assign d.is_set_bit = (op4 == OP_SET_BIT);
    assign d.is_skip_low = (op4 == OP_SKIP_LOW);
    assign d.is_skip_high = (op4 == OP_SKIP_HIGH);
    assign d.is_load_imm = (op4 == OP_LOAD_IMM);
    assign d.is_mask_imm = (op4 == OP_MASK_IMM);
endmodule : brl_decode

// file: core/brl_bitop.sv
// module: single-bit clear, set and test on a byte
`timescale 1ns/1ps
module brl_bitop import brl_pkg::*; (
    input wire logic [7:0] din, // operand byte
    input wire logic [2:0] sel, // bit number
    input wire logic val, // value forced into the bit
    output logic [7:0] dout, // byte with the bit forced
    output logic tbit // selected bit before change
);
    genvar i;
    generate
        for (i = 0; i < DATA_W; i++) begin : g_bit
            assign dout[i] = (sel == 3'(i)) ? val : din[i];
        end
    endgenerate
    assign tbit = din[sel];
endmodule : brl_bitop

// file: core/brl_exec.sv
// module: execution of invert, rotate, swap, bit and literal instructions
`timescale 1ns/1ps
module brl_exec import brl_pkg::*; (
    input wire logic clk_sys, // 50 MHz core clock
    input wire logic nrst, // synchronous reset, active low
    input wire logic insn_valid, // fetched word present this cycle
    input wire logic [11:0] insn_word, // fetched instruction word
    input wire logic [7:0] rf_rdata, // register file read data
    input wire logic [7:0] fsr_value, // file select register contents
    output logic [4:0] rf_raddr, // register file read address
    output logic rf_we, // register file write strobe
    output logic [4:0] rf_waddr, // register file write address
    output logic [7:0] rf_wdata, // register file write data
    output logic [7:0] acc, // accumulator
    output logic [2:0] status, // zero, digit carry, carry
    output logic skip_req, // next fetched word will be cancelled
    output logic busy // instruction in execute stage
);
    // ----------------------------------------------------------------
    // fetch stage: skip gating and operand address
    // ----------------------------------------------------------------
    logic skip_q, skip_d;
    logic [11:0] word_q;
    logic valid_q;
    brl_state_type state_q, state_d;
    logic [7:0] acc_q, acc_d;
    logic [2:0] st_q, st_d;
    logic we_q, we_d;
    logic [4:0] waddr_q;
    logic [7:0] wdata_q, wdata_d;
    logic [4:0] raddr_q;

    // a cancelled word is replaced by a no-op before decode
    wire take_word = insn_valid && !skip_q;
    wire [11:0] gated_word = take_word ? insn_word : NOP_WORD;
    wire [4:0] dir_addr = insn_word[FILE_HI:FILE_LO];
    // address 0 goes through the file select register
    wire [4:0] eff_addr = (dir_addr == INDIRECT_ADDR) ?
        fsr_value[FILE_HI:FILE_LO] : dir_addr;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            word_q <= NOP_WORD;
            valid_q <= 1'b0;
            raddr_q <= INDIRECT_ADDR;
        end else begin
            word_q <= gated_word;
            valid_q <= take_word;
            raddr_q <= eff_addr;
        end
    end

    // ----------------------------------------------------------------
    // execute stage: decode and datapath
    // ----------------------------------------------------------------
    brl_dec_if dif ();

    brl_decode u_dec (
        .insn(word_q),
        .d(dif.dec)
    );

    wire [7:0] src = rf_rdata;
    wire cin = st_q[ST_CARRY];
    wire bit_val = dif.is_set_bit;
    wire [7:0] bit_res;
    wire tested;

    brl_bitop u_bit (
        .din(src),
        .sel(dif.bit_num),
        .val(bit_val),
        .dout(bit_res),
        .tbit(tested)
    );

    wire [7:0] inv_res = ~src;
    wire [8:0] rl_ring = {src, cin};
    wire [7:0] rl_res = rl_ring[7:0];
    wire rl_cout = src[7];
    wire [7:0] rr_res = {cin, src[7:1]};
    wire rr_cout = src[0];
    wire [7:0] nx_res = {src[3:0], src[7:4]};
    wire [7:0] mask_res = acc_q & dif.literal;
    wire mask_zero = (mask_res == ZERO_BYTE);

    wire byte_op = dif.is_invert || dif.is_rot_left || dif.is_rot_right ||
        dif.is_nib_exch;
    wire bit_op = dif.is_clr_bit || dif.is_set_bit;
    wire [7:0] byte_res = dif.is_invert ? inv_res :
        dif.is_rot_left ? rl_res :
        dif.is_rot_right ? rr_res : nx_res;
    wire skip_hit = (dif.is_skip_low && !tested) ||
        (dif.is_skip_high && tested);

    always_comb begin
        acc_d = acc_q;
        st_d = st_q;
        we_d = 1'b0;
        wdata_d = wdata_q;
        skip_d = 1'b0;
        if (valid_q) begin
            if (byte_op) begin
                if (dif.dest_file) begin
                    we_d = 1'b1;
                    wdata_d = byte_res;
                end else begin
                    acc_d = byte_res;
                end
                // nibble exchange and invert leave carry as is
                if (dif.is_rot_left) begin
                    st_d[ST_CARRY] = rl_cout;
                end
                if (dif.is_rot_right) begin
                    st_d[ST_CARRY] = rr_cout;
                end
            end
            if (dif.is_invert) begin
                st_d[ST_ZERO] = (inv_res == ZERO_BYTE);
            end
            if (bit_op) begin
                we_d = 1'b1;
                wdata_d = bit_res;
            end
            skip_d = skip_hit;
            if (dif.is_load_imm) begin
                acc_d = dif.literal;
            end
            if (dif.is_mask_imm) begin
                acc_d = mask_res;
                st_d[ST_ZERO] = mask_zero;
            end
        end
    end

    // the state only tracks whether the execute stage holds a word; the
    // default branch pulls an illegal code back to idle
    always_comb begin
        case (state_q)
            BRL_IDLE: begin
                state_d = take_word ? BRL_EXEC : BRL_IDLE;
            end
            BRL_EXEC: begin
                state_d = take_word ? BRL_EXEC : BRL_IDLE;
            end
            default: begin
                state_d = BRL_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            acc_q <= ACC_RST;
            st_q <= STATUS_RST;
            we_q <= 1'b0;
            waddr_q <= INDIRECT_ADDR;
            wdata_q <= ZERO_BYTE;
            skip_q <= 1'b0;
            state_q <= BRL_IDLE;
        end else begin
            acc_q <= acc_d;
            st_q <= st_d;
            we_q <= we_d;
            waddr_q <= raddr_q;
            wdata_q <= wdata_d;
            skip_q <= skip_d;
            state_q <= state_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign rf_raddr = raddr_q;
    assign rf_we = we_q;
    assign rf_waddr = waddr_q;
    assign rf_wdata = wdata_q;
    assign acc = acc_q;
    assign status = st_q;
    assign skip_req = skip_q;
    assign busy = state_q[1]; // execute bit of the one-hot code

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    invert_write_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        valid_q && dif.is_invert && dif.dest_file |=> rf_we &&
        rf_wdata == ~$past(src) && acc == $past(acc_q))
        else $error("invert result wrong");
    dest_acc_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        valid_q && byte_op && !dif.dest_file |=> !rf_we)
        else $error("file written with destination 0");
    rotl_ring_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        valid_q && dif.is_rot_left && dif.dest_file |=>
        {status[ST_CARRY], rf_wdata} ==
        {$past(src), $past(cin)})
        else $error("left rotate ring wrong");
    rotl_flags_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        valid_q && dif.is_rot_left |=>
        status[2:1] == $past(st_q[2:1]))
        else $error("left rotate touched other flags");
    rotr_ring_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        valid_q && dif.is_rot_right && !dif.dest_file |=>
        acc == {$past(cin), $past(src[7:1])} &&
        status[ST_CARRY] == $past(src[0]))
        else $error("right rotate wrong");
    swap_flags_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        valid_q && (dif.is_nib_exch || bit_op || dif.is_load_imm) |=>
        $stable(status))
        else $error("flags changed");
    bit_clear_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        valid_q && dif.is_clr_bit |=> rf_we &&
        rf_wdata == ($past(src) & ~(8'h01 << $past(dif.bit_num))))
        else $error("bit clear wrong");
    skip_next_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        skip_q |=> !valid_q && !busy)
        else $error("skipped word executed");
    mask_zero_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        valid_q && dif.is_mask_imm |=>
        acc == ($past(acc_q) & $past(word_q[LIT_HI:LIT_LO])) &&
        status[ST_ZERO] == (acc == 8'h00))
        else $error("mask result or zero flag wrong");
    mask_flags_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        valid_q && dif.is_mask_imm |=> status[ST_DCARRY:ST_CARRY] ==
        $past(st_q[ST_DCARRY:ST_CARRY]))
        else $error("mask touched carry flags");
    bit_set_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        valid_q && dif.is_set_bit |=> rf_we &&
        rf_wdata == ($past(src) | (8'h01 << $past(dif.bit_num))))
        else $error("bit set wrong");
    load_imm_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        valid_q && dif.is_load_imm |=> !rf_we &&
        acc == $past(word_q[LIT_HI:LIT_LO]))
        else $error("load immediate wrong");
    no_write_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        valid_q && (dif.is_load_imm || dif.is_mask_imm) |=>
        !rf_we)
        else $error("literal word wrote the file");
    swap_result_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        valid_q && dif.is_nib_exch && !dif.dest_file |=>
        acc == {$past(src[3:0]), $past(src[7:4])})
        else $error("nibble exchange wrong");
    rotl_acc_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        valid_q && dif.is_rot_left && !dif.dest_file |=>
        acc == {$past(src[6:0]), $past(cin)})
        else $error("left rotate into accumulator wrong");
    invert_zero_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        valid_q && dif.is_invert |=>
        status[ST_ZERO] == ($past(src) == 8'hFF))
        else $error("invert zero flag wrong");

    // ----------------------------------------------------------------
    // assertions: fetch, addressing and skip
    // ----------------------------------------------------------------
    // expectations are rebuilt from the word and the read data, so a
    // broken selector cannot agree with itself
    fetch_take_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        insn_valid && !skip_req |=> busy)
        else $error("offered word not taken");
    direct_addr_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        insn_valid && insn_word[FILE_HI:FILE_LO] != INDIRECT_ADDR |=>
        rf_raddr == $past(insn_word[FILE_HI:FILE_LO]))
        else $error("direct operand address wrong");
    indirect_addr_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        insn_valid && insn_word[FILE_HI:FILE_LO] == INDIRECT_ADDR |=>
        rf_raddr == $past(fsr_value[FILE_HI:FILE_LO]))
        else $error("indirect operand address wrong");
    write_addr_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        valid_q && (bit_op || (byte_op && dif.dest_file)) |=>
        rf_we && rf_waddr == $past(rf_raddr))
        else $error("write address wrong");
    skip_low_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        valid_q && dif.is_skip_low |=> !rf_we && $stable(status) &&
        skip_req == !$past(src[dif.bit_num]))
        else $error("skip when low wrong");
    skip_high_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        valid_q && dif.is_skip_high |=> !rf_we && $stable(status) &&
        skip_req == $past(src[dif.bit_num]))
        else $error("skip when high wrong");
endmodule : brl_exec

// file: tb/brl_rf_model.sv
// register file model that answers the execute stage
`timescale 1ns/1ps
module brl_rf_model import brl_pkg::*; (
    input wire logic clk_sys, // core clock
    input wire logic [4:0] rf_raddr, // read address from the design
    input wire logic rf_we, // write strobe from the design
    input wire logic [4:0] rf_waddr, // write address from the design
    input wire logic [7:0] rf_wdata, // write data from the design
    input wire logic pre_we, // bench preload strobe
    input wire logic [4:0] pre_addr, // bench preload address
    input wire logic [7:0] pre_data, // bench preload data
    output logic [7:0] rf_rdata, // combinational read data
    output logic [7:0] fsr_value // file select register contents
);
    logic [7:0] mem_q [0:31];
    wire fwd_rd = rf_we && (rf_waddr == rf_raddr);
    wire fwd_fsr = rf_we && (rf_waddr == FSR_ADDR);

    // a write in flight is forwarded so back-to-back words see it
    assign rf_rdata = fwd_rd ? rf_wdata : mem_q[rf_raddr];
    assign fsr_value = fwd_fsr ? rf_wdata : mem_q[FSR_ADDR];

    always_ff @(posedge clk_sys) begin
        if (pre_we) begin
            mem_q[pre_addr] <= pre_data;
        end else if (rf_we) begin
            mem_q[rf_waddr] <= rf_wdata;
        end
    end
endmodule : brl_rf_model

// file: tb/tb_brl_exec.sv
// testbench: directed and random instruction stream with scoreboard
`timescale 1ns/1ps
module tb_brl_exec import brl_pkg::*;;
    typedef struct packed {
        logic chk;
        logic [4:0] ra;
        logic we;
        logic [4:0] wa;
        logic [7:0] wd;
        logic [7:0] ac;
        logic [2:0] st;
        logic sk;
    } brl_note_type;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic insn_valid = 1'b0;
    logic [11:0] insn_word = 12'h000;
    logic [7:0] rf_rdata, fsr_value, rf_wdata, acc;
    logic [4:0] rf_raddr, rf_waddr;
    logic rf_we, skip_req, busy;
    logic [2:0] status;
    logic pre_we = 1'b0;
    logic [4:0] pre_addr = 5'h00;
    logic [7:0] pre_data = 8'h00;
    integer seed = 32'h4416249A;
    int n_mismatch = 0;
    int comparisons = 0;
    logic [7:0] sh_mem [0:31];
    logic [7:0] acc_m = ACC_RST;
    logic [2:0] st_m = STATUS_RST;
    logic skip_pend = 1'b0;
    brl_note_type q [$];
    logic [5:0] byte_ops [4] = '{OP_INVERT, OP_ROT_RIGHT, OP_ROT_LEFT,
        OP_NIB_EXCH};
    logic [3:0] wide_ops [6] = '{OP_CLR_BIT, OP_SET_BIT, OP_SKIP_LOW,
        OP_SKIP_HIGH, OP_LOAD_IMM, OP_MASK_IMM};
    logic [11:0] dir_words [21] = '{12'h277, 12'h257, 12'hC49, 12'hE0F,
        12'hE00, 12'h370, 12'h370, 12'h370, 12'h310, 12'h387, 12'h447,
        12'h647, 12'hC55, 12'h747, 12'hC66, 12'h5E0, 12'h7E0, 12'hC77,
        12'h647, 12'h747, 12'hC88};

    initial begin
        forever #10 clk_sys = ~clk_sys;
    end

    brl_exec i_brl_exec (.clk_sys(clk_sys), .nrst(nrst),
        .insn_valid(insn_valid), .insn_word(insn_word),
        .rf_rdata(rf_rdata), .fsr_value(fsr_value), .rf_raddr(rf_raddr),
        .rf_we(rf_we), .rf_waddr(rf_waddr), .rf_wdata(rf_wdata),
        .acc(acc), .status(status), .skip_req(skip_req), .busy(busy));
    brl_rf_model i_brl_rf_model (.clk_sys(clk_sys), .rf_raddr(rf_raddr),
        .rf_we(rf_we), .rf_waddr(rf_waddr), .rf_wdata(rf_wdata),
        .pre_we(pre_we), .pre_addr(pre_addr), .pre_data(pre_data),
        .rf_rdata(rf_rdata), .fsr_value(fsr_value));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic close_out;
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out

    // ----------------------------------------------------------------
    // reference model: one call per offered word
    // ----------------------------------------------------------------
    task automatic issue(input logic [11:0] w);
        brl_note_type n;
        logic [4:0] a;
        logic [7:0] v;
        logic [7:0] r;
        @(negedge clk_sys);
        insn_valid = 1'b1;
        insn_word = w;
        if (skip_pend) begin
            skip_pend = 1'b0;
            return;
        end
        a = (w[4:0] == INDIRECT_ADDR) ? sh_mem[FSR_ADDR][4:0] : w[4:0];
        v = sh_mem[a];
        r = v;
        n = '{1'b1, a, 1'b0, a, 8'h00, 8'h00, 3'h0, 1'b0};
        case (w[11:6])
            OP_INVERT: r = ~v;
            OP_ROT_RIGHT: {r, st_m[ST_CARRY]} = {st_m[ST_CARRY], v};
            OP_ROT_LEFT: {st_m[ST_CARRY], r} = {v, st_m[ST_CARRY]};
            OP_NIB_EXCH: r = {v[3:0], v[7:4]};
            default: ;
        endcase
        if (w[11:6] == OP_INVERT) st_m[ST_ZERO] = (r == ZERO_BYTE);
        if (w[11:6] inside {OP_INVERT, OP_ROT_RIGHT, OP_ROT_LEFT,
            OP_NIB_EXCH}) begin
            if (w[DEST_POS]) begin
                n.we = 1'b1;
                sh_mem[a] = r;
            end else begin
                acc_m = r;
            end
        end
        // bit 8 of the opcode is the forced value and the skip polarity
        case (w[11:8])
            OP_CLR_BIT, OP_SET_BIT: begin
                r[w[7:5]] = w[8];
                n.we = 1'b1;
                sh_mem[a] = r;
            end
            OP_SKIP_LOW, OP_SKIP_HIGH: begin
                skip_pend = (v[w[7:5]] == w[8]);
            end
            OP_LOAD_IMM: begin
                n.chk = 1'b0;
                acc_m = w[7:0];
            end
            OP_MASK_IMM: begin
                n.chk = 1'b0;
                acc_m = acc_m & w[7:0];
                st_m[ST_ZERO] = (acc_m == ZERO_BYTE);
            end
            default: ;
        endcase
        n.wd = r;
        n.ac = acc_m;
        n.st = st_m;
        n.sk = skip_pend;
        q.push_back(n);
        // a bubble after a test lets the cancelled slot be the next word
        if (w[11:9] == 3'h3) begin
            @(negedge clk_sys);
            insn_valid = 1'b0;
        end
    endtask : issue

    // ----------------------------------------------------------------
    // output watcher
    // ----------------------------------------------------------------
    initial begin
        brl_note_type n;
        forever begin
            @(negedge clk_sys);
            if (busy === 1'b1) begin
                n = q.pop_front();
                if (n.chk) check(8'(rf_raddr), 8'(n.ra));
                @(posedge clk_sys);
                #1;
                check(8'(rf_we), 8'(n.we));
                if (n.we) check(8'(rf_waddr), 8'(n.wa));
                if (n.we) check(rf_wdata, n.wd);
                check(acc, n.ac);
                check(8'(status), 8'(n.st));
                check(8'(skip_req), 8'(n.sk));
            end
        end
    end

    initial begin
        #200000;
        n_mismatch++;
        close_out();
    end

    initial begin
        logic [11:0] w;
        logic [4:0] f;
        int k;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        nrst = 1'b1;
        check(acc, ACC_RST);
        check(8'(status), 8'(STATUS_RST));
        check(8'({rf_we, skip_req, busy}), 8'h00);
        for (k = 0; k < 32; k++) begin
            sh_mem[k] = 8'($random(seed));
            case (k)
                4: sh_mem[k] = 8'h13;
                16: sh_mem[k] = 8'h35;
                23: sh_mem[k] = 8'h76;
                default: ;
            endcase
            pre_we = 1'b1;
            pre_addr = 5'(k);
            pre_data = sh_mem[k];
            @(negedge clk_sys);
        end
        pre_we = 1'b0;
        foreach (dir_words[i]) issue(dir_words[i]);
        // random words; direct address 4 is avoided so the pointer holds
        repeat (300) begin
            k = $unsigned($random(seed)) % 10;
            f = 5'($unsigned($random(seed)) % 28);
            if (f != 5'h00) f = f + 5'h04;
            w = 12'($random(seed));
            if (k < 4) w[11:6] = byte_ops[k];
            else w[11:8] = wide_ops[k - 4];
            if (k < 8) w[4:0] = f;
            issue(w);
        end
        @(negedge clk_sys);
        insn_valid = 1'b0;
        repeat (4) @(negedge clk_sys);
        check(8'(q.size()), 8'h00);
        close_out();
    end
endmodule : tb_brl_exec
